// >>> gyro_power_and_user_control.sv
// Control registers for FIFO, host port, reset, sleep, clock source and axis standby
`default_nettype none

// Behaviour
// - Port select one switches host to SPI
// - Reset bits act, then clear themselves
// - Master enable low blocks FIFO reads only
// - FIFO kept unless flushed or chip reset
// - Flush bit empties FIFO, then self-clears
// - Signal path clear resets paths and outputs
// - Whole chip reset restores defaults, self-clears
// - Sleep bit one enters low-power sleep
// - Thermal bit one switches temperature sensor off
// - Codes 0,6 oscillator; 1-5 PLL; 7 reserved
// - PLL is the source after power-up
// - Oscillator source runs with gyros all off
// - Per-axis standby bit idles that axis
// - All standby on PLL stops device clock
// - One active axis keeps drive and PLL
// - User control bits 7,5,3,1 are dead
module gyro_power_and_user_control (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic clock_enable,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_address,
	input wire logic [7:0] reg_write_data,
	output var logic [7:0] reg_read_data,
	output var logic reg_read_valid,
	output var logic fifo_read_allow,
	output var logic fifo_clear,
	output var logic signal_path_clear_pulse,
	output var logic whole_chip_reset_pulse,
	output var logic serial_port_select,
	output var logic sleep_mode,
	output var logic thermal_sensor_off,
	output var logic use_pll_clock,
	output var logic x_rate_axis_standby,
	output var logic y_rate_axis_standby,
	output var logic z_rate_axis_standby,
	output var logic gyro_drive_on,
	output var logic clock_halted
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic fifo_master_enable;
		logic serial_port_select;
		logic sleep_mode;
		logic thermal_sensor_off;
		logic [2:0] clock_source_choice;
		logic use_pll;
		logic [gyro_ctrl_pkg::AXIS_COUNT-1:0] standby_bits;
		logic [gyro_ctrl_pkg::AXIS_COUNT-1:0] axis_off;
		logic halted;
		logic drive_on;
		logic fifo_clear;
		logic [7:0] read_data;
		logic read_valid;
	} state_t;

	state_t state;
	state_t next_state;

	logic accept;
	logic write_user;
	logic write_power_one;
	logic write_power_two;
	logic fifo_flush_pulse;
	logic path_pulse;
	logic chip_pulse;
	logic [7:0] user_view;
	logic [7:0] power_one_view;
	logic [7:0] power_two_view;
	logic [2:0] new_code;
	logic [gyro_ctrl_pkg::AXIS_COUNT-1:0] new_standby;

	// A hung device ignores the host until arst_n resets it
	assign accept = clock_enable && !state.halted;
	assign write_user = accept && reg_write && reg_address == gyro_ctrl_pkg::USER_CONTROL_ADDR;
	assign write_power_one = accept && reg_write
		&& reg_address == gyro_ctrl_pkg::POWER_CONTROL_ONE_ADDR;
	assign write_power_two = accept && reg_write
		&& reg_address == gyro_ctrl_pkg::POWER_CONTROL_TWO_ADDR;
	assign new_code = reg_write_data[gyro_ctrl_pkg::CLOCK_SOURCE_CHOICE_LSB
		+: gyro_ctrl_pkg::CLOCK_SOURCE_CHOICE_WIDTH];
	assign new_standby = {reg_write_data[gyro_ctrl_pkg::X_RATE_AXIS_STANDBY_BIT],
		reg_write_data[gyro_ctrl_pkg::Y_RATE_AXIS_STANDBY_BIT],
		reg_write_data[gyro_ctrl_pkg::Z_RATE_AXIS_STANDBY_BIT]};

	// ****************************************
	// Self-clearing reset bits
	// ****************************************
	self_clear_pulse u_fifo_flush (
		.clock(clock),
		.arst_n(arst_n),
		.clock_enable(accept),
		.fire(write_user && reg_write_data[gyro_ctrl_pkg::FIFO_FLUSH_BIT]),
		.pulse(fifo_flush_pulse)
	);

	self_clear_pulse u_path_clear (
		.clock(clock),
		.arst_n(arst_n),
		.clock_enable(accept),
		.fire(write_user && reg_write_data[gyro_ctrl_pkg::SIGNAL_PATH_CLEAR_BIT]),
		.pulse(path_pulse)
	);

	self_clear_pulse u_chip_reset (
		.clock(clock),
		.arst_n(arst_n),
		.clock_enable(accept),
		.fire(write_power_one && reg_write_data[gyro_ctrl_pkg::WHOLE_CHIP_RESET_BIT]),
		.pulse(chip_pulse)
	);

	// ****************************************
	// Read views
	// ****************************************
	always_comb begin
		user_view = 8'h00;
		user_view[gyro_ctrl_pkg::FIFO_MASTER_ENABLE_BIT] = state.fifo_master_enable;
		user_view[gyro_ctrl_pkg::SERIAL_PORT_SELECT_BIT] = state.serial_port_select;
		user_view[gyro_ctrl_pkg::FIFO_FLUSH_BIT] = fifo_flush_pulse;
		user_view[gyro_ctrl_pkg::SIGNAL_PATH_CLEAR_BIT] = path_pulse;
		power_one_view = 8'h00;
		power_one_view[gyro_ctrl_pkg::WHOLE_CHIP_RESET_BIT] = chip_pulse;
		power_one_view[gyro_ctrl_pkg::SLEEP_BIT] = state.sleep_mode;
		power_one_view[gyro_ctrl_pkg::THERMAL_SENSOR_OFF_BIT] = state.thermal_sensor_off;
		power_one_view[gyro_ctrl_pkg::CLOCK_SOURCE_CHOICE_LSB
			+: gyro_ctrl_pkg::CLOCK_SOURCE_CHOICE_WIDTH] = state.clock_source_choice;
		power_two_view = 8'h00;
		power_two_view[gyro_ctrl_pkg::X_RATE_AXIS_STANDBY_BIT] = state.standby_bits[2];
		power_two_view[gyro_ctrl_pkg::Y_RATE_AXIS_STANDBY_BIT] = state.standby_bits[1];
		power_two_view[gyro_ctrl_pkg::Z_RATE_AXIS_STANDBY_BIT] = state.standby_bits[0];
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_state = state;
		next_state.read_valid = accept && reg_read;
		// Chip reset also empties the FIFO, master enable alone never does
		next_state.fifo_clear = fifo_flush_pulse || chip_pulse;
		if (accept && reg_read) begin
			case (reg_address)
				gyro_ctrl_pkg::USER_CONTROL_ADDR: next_state.read_data = user_view;
				gyro_ctrl_pkg::POWER_CONTROL_ONE_ADDR: next_state.read_data = power_one_view;
				gyro_ctrl_pkg::POWER_CONTROL_TWO_ADDR: next_state.read_data = power_two_view;
				default: next_state.read_data = gyro_ctrl_pkg::READ_IDLE_VALUE;
			endcase
		end
		if (write_user) begin
			next_state.fifo_master_enable =
				reg_write_data[gyro_ctrl_pkg::FIFO_MASTER_ENABLE_BIT];
			next_state.serial_port_select =
				reg_write_data[gyro_ctrl_pkg::SERIAL_PORT_SELECT_BIT];
		end
		if (write_power_one) begin
			next_state.sleep_mode = reg_write_data[gyro_ctrl_pkg::SLEEP_BIT];
			next_state.thermal_sensor_off =
				reg_write_data[gyro_ctrl_pkg::THERMAL_SENSOR_OFF_BIT];
			next_state.clock_source_choice = new_code;
			// Reserved code leaves the running source untouched
			if (new_code >= gyro_ctrl_pkg::CLOCK_CODE_PLL_FIRST
				&& new_code <= gyro_ctrl_pkg::CLOCK_CODE_PLL_LAST) begin
				next_state.use_pll = 1'b1;
			end else if (new_code == gyro_ctrl_pkg::CLOCK_CODE_OSC_LOW
				|| new_code == gyro_ctrl_pkg::CLOCK_CODE_OSC_HIGH) begin
				next_state.use_pll = 1'b0;
			end
		end
		if (write_power_two) begin
			next_state.standby_bits = new_standby;
			// Clearing brings axes back only from the all-standby state
			if (&state.axis_off) begin
				next_state.axis_off = new_standby;
			end else begin
				next_state.axis_off = state.axis_off | new_standby;
			end
		end
		if (chip_pulse) begin
			next_state.fifo_master_enable = 1'b0;
			next_state.serial_port_select = 1'b0;
			next_state.sleep_mode = 1'b0;
			next_state.thermal_sensor_off = 1'b0;
			next_state.clock_source_choice = gyro_ctrl_pkg::CLOCK_SOURCE_CHOICE_RESET;
			next_state.use_pll = gyro_ctrl_pkg::USE_PLL_RESET;
			next_state.standby_bits = gyro_ctrl_pkg::STANDBY_RESET;
			next_state.axis_off = gyro_ctrl_pkg::STANDBY_RESET;
		end
		// PLL loses its reference once the gyro drive stops
		if (&next_state.axis_off && next_state.use_pll) begin
			next_state.halted = 1'b1;
		end
		// Registered so the drive flag moves on the same edge as the axes
		next_state.drive_on = ~&next_state.axis_off;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state <= '0;
			state.clock_source_choice <= gyro_ctrl_pkg::CLOCK_SOURCE_CHOICE_RESET;
			state.use_pll <= gyro_ctrl_pkg::USE_PLL_RESET;
			state.standby_bits <= gyro_ctrl_pkg::STANDBY_RESET;
			state.axis_off <= gyro_ctrl_pkg::STANDBY_RESET;
			state.drive_on <= ~&gyro_ctrl_pkg::STANDBY_RESET;
			state.read_data <= gyro_ctrl_pkg::READ_IDLE_VALUE;
		end else if (clock_enable) begin
			state <= next_state;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign reg_read_data = state.read_data;
	assign reg_read_valid = state.read_valid;
	assign fifo_read_allow = state.fifo_master_enable;
	assign fifo_clear = state.fifo_clear;
	assign signal_path_clear_pulse = path_pulse;
	assign whole_chip_reset_pulse = chip_pulse;
	assign serial_port_select = state.serial_port_select;
	assign sleep_mode = state.sleep_mode;
	assign thermal_sensor_off = state.thermal_sensor_off;
	assign use_pll_clock = state.use_pll;
	assign x_rate_axis_standby = state.axis_off[2];
	assign y_rate_axis_standby = state.axis_off[1];
	assign z_rate_axis_standby = state.axis_off[0];
	assign gyro_drive_on = state.drive_on;
	assign clock_halted = state.halted;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n || !clock_enable);

	sequence flush_request;
		write_user && reg_write_data[gyro_ctrl_pkg::FIFO_FLUSH_BIT];
	endsequence

	sequence flush_then_idle;
		##1 fifo_flush_pulse ##1 (!fifo_flush_pulse && fifo_clear);
	endsequence

	a_flush_one_pulse: assert property (flush_request |-> flush_then_idle)
		else $error("fifo flush pulse not single cycle");

	sequence chip_request;
		write_power_one && reg_write_data[gyro_ctrl_pkg::WHOLE_CHIP_RESET_BIT];
	endsequence

	sequence chip_then_cleared;
		##1 whole_chip_reset_pulse ##1 (!whole_chip_reset_pulse && fifo_clear);
	endsequence

	// Soft reset must empty the FIFO too, not only restore the fields
	a_chip_pulse_once: assert property (chip_request |-> chip_then_cleared)
		else $error("chip reset pulse not single cycle");

	a_path_clear_pulse: assert property (
		write_user && reg_write_data[gyro_ctrl_pkg::SIGNAL_PATH_CLEAR_BIT]
		|=> signal_path_clear_pulse ##1 !signal_path_clear_pulse)
		else $error("signal path clear did not self clear");

	a_port_select_follows: assert property (
		write_user && !chip_pulse |=> serial_port_select == $past(reg_write_data[4]))
		else $error("serial port select wrong after write");

	a_fifo_read_gate: assert property (
		write_user && !chip_pulse && !reg_write_data[6] |=> !fifo_read_allow)
		else $error("fifo reads allowed while disabled");

	a_chip_reset_defaults: assert property (
		chip_pulse |=> use_pll_clock && !sleep_mode && !serial_port_select && !chip_pulse)
		else $error("chip reset did not restore defaults");

	a_osc_codes: assert property (
		write_power_one && !chip_pulse && (new_code == 3'h0 || new_code == 3'h6)
		|=> !use_pll_clock)
		else $error("oscillator code did not select oscillator");

	a_reserved_user_bits: assert property (
		reg_read_valid && $past(reg_address) == gyro_ctrl_pkg::USER_CONTROL_ADDR
		|-> (reg_read_data & 8'hAA) == 8'h00)
		else $error("reserved user control bits read non zero");

	a_pll_hang: assert property (
		write_power_two && (&new_standby) && use_pll_clock && !chip_pulse |=> clock_halted)
		else $error("all axes idle on pll without halt");

	a_halt_sticky: assert property (
		clock_halted |=> clock_halted)
		else $error("hang released without reset");

	a_halt_refuses: assert property (
		clock_halted |=> !reg_read_valid)
		else $error("read answered while hung");

	a_wake_together: assert property (
		write_power_two && !(&state.axis_off) && !chip_pulse
		|=> (state.axis_off & $past(state.axis_off)) == $past(state.axis_off))
		else $error("axis woke without all standby first");

	a_drive_kept: assert property (
		!(&state.axis_off) |-> gyro_drive_on && !$rose(clock_halted))
		else $error("drive lost with an axis active");

	a_sleep_follows: assert property (
		write_power_one && !chip_pulse |=> sleep_mode == $past(reg_write_data[6]))
		else $error("sleep bit not applied");

endmodule

`default_nettype wire

// >>> gyro_ctrl_pkg.sv
// Package with register map, field positions and reset values of the control block
`default_nettype none

package gyro_ctrl_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] USER_CONTROL_ADDR = 8'h6A;
	localparam logic [7:0] POWER_CONTROL_ONE_ADDR = 8'h6B;
	localparam logic [7:0] POWER_CONTROL_TWO_ADDR = 8'h6C;

	// ****************************************
	// User control fields
	// ****************************************
	localparam int SIGNAL_PATH_CLEAR_BIT = 0;
	localparam int FIFO_FLUSH_BIT = 2;
	localparam int SERIAL_PORT_SELECT_BIT = 4;
	localparam int FIFO_MASTER_ENABLE_BIT = 6;

	// ****************************************
	// Power control one fields
	// ****************************************
	localparam int CLOCK_SOURCE_CHOICE_LSB = 0;
	localparam int CLOCK_SOURCE_CHOICE_WIDTH = 3;
	localparam int THERMAL_SENSOR_OFF_BIT = 3;
	localparam int SLEEP_BIT = 6;
	localparam int WHOLE_CHIP_RESET_BIT = 7;

	// ****************************************
	// Power control two fields
	// ****************************************
	localparam int Z_RATE_AXIS_STANDBY_BIT = 0;
	localparam int Y_RATE_AXIS_STANDBY_BIT = 1;
	localparam int X_RATE_AXIS_STANDBY_BIT = 2;
	localparam int AXIS_COUNT = 3;

	// ****************************************
	// Clock source codes and reset values
	// ****************************************
	localparam logic [2:0] CLOCK_CODE_OSC_LOW = 3'h0;
	localparam logic [2:0] CLOCK_CODE_PLL_FIRST = 3'h1;
	localparam logic [2:0] CLOCK_CODE_PLL_LAST = 3'h5;
	localparam logic [2:0] CLOCK_CODE_OSC_HIGH = 3'h6;
	localparam logic [2:0] CLOCK_CODE_RESERVED = 3'h7;
	localparam logic [2:0] CLOCK_SOURCE_CHOICE_RESET = 3'h1;
	localparam logic USE_PLL_RESET = 1'b1;
	localparam logic [AXIS_COUNT-1:0] STANDBY_RESET = 3'h0;
	localparam logic [7:0] READ_IDLE_VALUE = 8'h00;

endpackage

`default_nettype wire

// >>> self_clear_pulse.sv
// One-shot pulse generator behind a self-clearing control bit
`default_nettype none

module self_clear_pulse (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic clock_enable,
	input wire logic fire,
	output var logic pulse
);

	typedef struct packed {
		logic pulse;
	} state_t;

	state_t state;
	state_t next_state;

	// Pulse lasts exactly one enabled cycle, then the bit reads as zero
	always_comb begin
		next_state = state;
		next_state.pulse = fire;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state <= '0;
		end else if (clock_enable) begin
			state <= next_state;
		end
	end

	assign pulse = state.pulse;

endmodule

`default_nettype wire

// >>> gyro_host_model.sv
// Host processor model that drives the control register port
`default_nettype none

module gyro_host_model (
	input wire logic clock,
	output var logic reg_write,
	output var logic reg_read,
	output var logic [7:0] reg_address,
	output var logic [7:0] reg_write_data,
	input wire logic [7:0] reg_read_data,
	input wire logic reg_read_valid
);
	timeunit 1ns;
	timeprecision 100ps;

	// ********
	// Bus cycles
	// ********
	initial begin
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_address = 8'h00;
		reg_write_data = 8'h00;
	end

	// Released lines show the inverse, so stale values never look valid
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clock);
		#1;
		reg_write = 1'b1;
		reg_address = addr;
		reg_write_data = data;
		@(posedge clock);
		#1;
		reg_write = 1'b0;
		reg_address = ~addr;
		reg_write_data = ~data;
	endtask

	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
		ok = 1'b0;
		data = 8'h00;
		@(posedge clock);
		#1;
		reg_read = 1'b1;
		reg_address = addr;
		@(posedge clock);
		#1;
		reg_read = 1'b0;
		reg_address = ~addr;
		for (int i = 0; i < 4; i++) begin
			if (reg_read_valid === 1'b1) begin
				data = reg_read_data;
				ok = 1'b1;
				break;
			end
			@(posedge clock);
			#1;
		end
	endtask
endmodule

`default_nettype wire

// >>> gyro_power_and_user_control_tb.sv
// Self-checking bench of the power and user control registers
`default_nettype none

module gyro_power_and_user_control_tb;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [7:0] UC = gyro_ctrl_pkg::USER_CONTROL_ADDR;
	localparam logic [7:0] P1 = gyro_ctrl_pkg::POWER_CONTROL_ONE_ADDR;
	localparam logic [7:0] P2 = gyro_ctrl_pkg::POWER_CONTROL_TWO_ADDR;
	logic clock, arst_n, clock_enable, reg_write, reg_read, reg_read_valid;
	logic [7:0] reg_address, reg_write_data, reg_read_data, d;
	logic fifo_read_allow, fifo_clear, signal_path_clear_pulse, whole_chip_reset_pulse;
	logic serial_port_select, sleep_mode, thermal_sensor_off, use_pll_clock;
	logic x_rate_axis_standby, y_rate_axis_standby, z_rate_axis_standby;
	logic gyro_drive_on, clock_halted, ok;
	int fail_count = 0;
	int compares = 0;

	gyro_power_and_user_control gyro_power_and_user_control_i (.clock, .arst_n, .clock_enable,
		.reg_write, .reg_read, .reg_address, .reg_write_data, .reg_read_data, .reg_read_valid,
		.fifo_read_allow, .fifo_clear, .signal_path_clear_pulse, .whole_chip_reset_pulse,
		.serial_port_select, .sleep_mode, .thermal_sensor_off, .use_pll_clock,
		.x_rate_axis_standby, .y_rate_axis_standby, .z_rate_axis_standby,
		.gyro_drive_on, .clock_halted);

	gyro_host_model gyro_host_model_i (.clock, .reg_write, .reg_read, .reg_address,
		.reg_write_data, .reg_read_data, .reg_read_valid);

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// ********
	// Helpers
	// ********
	task automatic end_of_test();
		$display("Compares %0d, errors %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		check({7'h00, got}, {7'h00, exp});
	endtask

	task automatic step();
		@(posedge clock);
		#1;
	endtask

	task automatic reset_dut(input int n);
		arst_n = 1'b0;
		repeat (n) @(posedge clock);
		#1;
		arst_n = 1'b1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		gyro_host_model_i.write_reg(a, v);
	endtask

	// A missing answer ends the run at once
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		gyro_host_model_i.read_reg(a, d, ok);
		if (ok !== 1'b1) begin
			fail_count++;
			end_of_test();
		end else begin
			check(d, exp);
		end
	endtask

	// ********
	// Scenarios
	// ********
	task automatic t_reset();
		check_bit(use_pll_clock, 1'b1);
		check_bit(gyro_drive_on, 1'b1);
		rd(UC, 8'h00);
		rd(P1, 8'h01);
		rd(P2, 8'h00);
	endtask

	task automatic t_user();
		wr(UC, 8'hFF);
		check_bit(fifo_read_allow, 1'b1);
		check_bit(serial_port_select, 1'b1);
		rd(UC, 8'h50);
		wr(UC, 8'h00);
		check_bit(fifo_read_allow, 1'b0);
		check_bit(serial_port_select, 1'b0);
	endtask

	task automatic t_flush();
		wr(UC, 8'h40);
		wr(UC, 8'h00);
		for (int i = 0; i < 3; i++) begin
			check_bit(fifo_clear, 1'b0);
			step();
		end
		wr(UC, 8'h05);
		check_bit(signal_path_clear_pulse, 1'b1);
		check_bit(fifo_clear, 1'b0);
		step();
		check_bit(signal_path_clear_pulse, 1'b0);
		check_bit(fifo_clear, 1'b1);
		step();
		check_bit(fifo_clear, 1'b0);
		rd(UC, 8'h00);
	endtask

	// Code 7 keeps the previous source
	task automatic t_clock();
		logic exp;
		exp = 1'b1;
		for (int c = 0; c < 8; c++) begin
			wr(P1, 8'h48 | 8'(c));
			if (c != 7) exp = (c >= 1 && c <= 5);
			check_bit(use_pll_clock, exp);
			check_bit(sleep_mode, 1'b1);
			check_bit(thermal_sensor_off, 1'b1);
			rd(P1, 8'h48 | 8'(c));
		end
	endtask

	task automatic t_chip_reset();
		wr(UC, 8'h50);
		wr(P1, 8'h80);
		check_bit(whole_chip_reset_pulse, 1'b1);
		step();
		check_bit(whole_chip_reset_pulse, 1'b0);
		check_bit(fifo_clear, 1'b1);
		check_bit(fifo_read_allow, 1'b0);
		check_bit(serial_port_select, 1'b0);
		check_bit(sleep_mode, 1'b0);
		check_bit(use_pll_clock, 1'b1);
		rd(P1, 8'h01);
		rd(UC, 8'h00);
	endtask

	task automatic t_standby();
		wr(P1, 8'h00);
		wr(P2, 8'h01);
		check_bit(z_rate_axis_standby, 1'b1);
		check_bit(gyro_drive_on, 1'b1);
		wr(P2, 8'h00);
		check_bit(z_rate_axis_standby, 1'b1);
		wr(P2, 8'h07);
		check_bit(x_rate_axis_standby, 1'b1);
		check_bit(y_rate_axis_standby, 1'b1);
		check_bit(gyro_drive_on, 1'b0);
		check_bit(clock_halted, 1'b0);
		rd(P2, 8'h07);
		wr(P2, 8'h00);
		rd(P2, 8'h00);
		check_bit(x_rate_axis_standby | y_rate_axis_standby | z_rate_axis_standby, 1'b0);
		check_bit(gyro_drive_on, 1'b1);
	endtask

	// Broken host order on purpose, then recovery by reset
	task automatic t_hang();
		wr(P1, 8'h01);
		wr(P2, 8'h07);
		check_bit(clock_halted, 1'b1);
		gyro_host_model_i.read_reg(P1, d, ok);
		check_bit(ok, 1'b0);
		reset_dut(1);
		step();
		check_bit(clock_halted, 1'b0);
		rd(P2, 8'h00);
	endtask

	task automatic t_misc();
		clock_enable = 1'b0;
		wr(UC, 8'h40);
		clock_enable = 1'b1;
		check_bit(fifo_read_allow, 1'b0);
		wr(8'h10, 8'h40);
		check_bit(fifo_read_allow, 1'b0);
		rd(8'h10, 8'h00);
	endtask

	initial begin
		clock_enable = 1'b1;
		reset_dut(6);
		t_reset();
		t_user();
		t_flush();
		t_clock();
		t_chip_reset();
		t_standby();
		t_hang();
		t_misc();
		end_of_test();
	end
endmodule

`default_nettype wire
